// [rfdma_pkg.sv]
package rfdma_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [11:0] RFDMA_IDX_CTRL = 12'hFB0;
    localparam logic [11:0] RFDMA_IDX_PERIPH = 12'hFB1;
    localparam logic [11:0] RFDMA_IDX_HIGH = 12'hFB2;
    localparam logic [11:0] RFDMA_IDX_START = 12'hFB3;
    localparam logic [11:0] RFDMA_IDX_END = 12'hFB4;
    localparam int RFDMA_IDX_W = 12;
    localparam int RFDMA_IDX_LSB = 2;

    // Control field layout
    localparam int RFDMA_CTL_EN = 7;
    localparam int RFDMA_CTL_LOOP = 6;
    localparam int RFDMA_CTL_DIR = 5;
    localparam int RFDMA_CTL_IE = 4;
    localparam int RFDMA_CTL_WORD = 3;
    localparam int RFDMA_CTL_TRIG_HI = 2;
    localparam int RFDMA_CTL_TRIG_LO = 0;

    // High nibble register layout
    localparam int RFDMA_HI_START_HI = 7;
    localparam int RFDMA_HI_START_LO = 4;
    localparam int RFDMA_HI_END_HI = 3;
    localparam int RFDMA_HI_END_LO = 0;

    localparam logic [7:0] RFDMA_REG_RESET = 8'h00;
    localparam logic [3:0] RFDMA_PERIPH_PAGE = 4'hF;

    // Trigger source codes
    localparam logic [2:0] RFDMA_TRIG_TIMER0 = 3'h0;
    localparam logic [2:0] RFDMA_TRIG_TIMER3 = 3'h3;
    localparam logic [2:0] RFDMA_TRIG_UART0 = 3'h4;
    localparam logic [2:0] RFDMA_TRIG_UART1 = 3'h5;
    localparam logic [2:0] RFDMA_TRIG_I2C = 3'h6;
    localparam logic [2:0] RFDMA_TRIG_RSVD = 3'h7;

    typedef enum logic [3:0] {
        RFDMA_IDLE = 4'b0001,
        RFDMA_MOVE = 4'b0010,
        RFDMA_WAIT = 4'b0100,
        RFDMA_NEXT = 4'b1000
    } rfdma_state_t;
endpackage

// [rfdma_trig_sel.sv]
`timescale 1ns/1ns
module rfdma_trig_sel
    import rfdma_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] trig_sel,
    input wire logic [3:0] timer_req,
    input wire logic [1:0] uart_rx_valid,
    input wire logic i2c_rx_valid,
    output logic trig_pulse
);
    logic sel_level;
    logic sel_last;

    // Codes 000..011 are timers 0..3, 100/101 UARTs, 110 I2C, 111 never fires
    always_comb
    begin
        sel_level = 1'b0;
        if (trig_sel <= RFDMA_TRIG_TIMER3)
            sel_level = timer_req[trig_sel[1:0]];
        else if (trig_sel == RFDMA_TRIG_UART0)
            sel_level = uart_rx_valid[0];
        else if (trig_sel == RFDMA_TRIG_UART1)
            sel_level = uart_rx_valid[1];
        else if (trig_sel == RFDMA_TRIG_I2C)
            sel_level = i2c_rx_valid;
        else
            sel_level = 1'b0;
    end

    // Rising edge only: data-valid levels stay high until the data is read
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sel_last <= 1'b0;
        else
            sel_last <= sel_level;
    end

    assign trig_pulse = sel_level & ~sel_last;
endmodule

// [rfdma_byte_mover.sv]
`timescale 1ns/1ns
module rfdma_byte_mover
    import rfdma_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic [11:0] src_addr,
    input wire logic [11:0] dst_addr,
    output logic done,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_rd,
    output logic mem_wr,
    input wire logic [7:0] mem_rdata
);
    // Read cycle, data taken on the edge ending it, then write cycle
    logic rd_phase;
    logic wr_phase;
    logic [11:0] dst_hold;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rd_phase <= 1'b0;
            wr_phase <= 1'b0;
            dst_hold <= 12'h000;
        end
        else
        begin
            rd_phase <= go;
            wr_phase <= rd_phase;
            if (go)
                dst_hold <= dst_addr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mem_addr <= 12'h000;
            mem_wdata <= 8'h00;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
        end
        else
        begin
            mem_rd <= go;
            mem_wr <= rd_phase;
            if (go)
                mem_addr <= src_addr;
            else if (rd_phase)
                mem_addr <= dst_hold;
            if (rd_phase)
                mem_wdata <= mem_rdata;
        end
    end

    assign done = wr_phase;
endmodule

// [rfdma_channel.sv]
`timescale 1ns/1ns
//
// Contract
// - Three-bit field picks timer 0-3, UART 0/1, I2C or none as trigger.
// - Word select clear moves one byte per request, set moves two unless the first is the end-address byte.
// - With interrupt enable set, pulse interrupt after end-address byte moves.
// - Direction clear copies register file to peripheral, set copies back.
// - At end address, start is reloaded; loop clear also disables channel.
// - Requests are serviced only while the enable control is set.
// - Start and end are 12 bits; upper nibbles share one register.
// - Start low register also reads back the current address pointer.
// - End low byte separate; full 12-bit compare detects block end.
// - Peripheral address is its byte placed in register-file page F.
module rfdma_channel
    import rfdma_pkg::*;
#(
    parameter int AV_ADDR_W = 14
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] timer_req,
    input wire logic [1:0] uart_rx_valid,
    input wire logic i2c_rx_valid,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_rd,
    output logic mem_wr,
    input wire logic [7:0] mem_rdata,
    output logic dma_irq
);
    if (AV_ADDR_W < RFDMA_IDX_W + RFDMA_IDX_LSB)
        $error("rfdma_channel: AV_ADDR_W too small for register map");

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] channel_control;
    logic [7:0] peripheral_reg_address;
    logic [3:0] start_hi_saved;
    logic [7:0] start_lo_saved;
    logic [11:0] cur_addr;
    logic [3:0] end_hi;
    logic [7:0] end_address_low;

    rfdma_state_t state;
    logic second_byte;
    logic pair_more;
    logic trig_pulse;
    logic move_go;
    logic move_done;
    logic at_end;
    logic [7:0] periph_byte;
    logic [11:0] periph_full;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;

    // ------------------------------------------------------------
    // Layout checks: fields must fit the byte registers they live in
    // ------------------------------------------------------------
    if (RFDMA_CTL_TRIG_HI - RFDMA_CTL_TRIG_LO + 1 != $bits(RFDMA_TRIG_RSVD))
        $error("rfdma_channel: trigger field width disagrees with its codes");
    if (RFDMA_CTL_EN >= $bits(channel_control) || RFDMA_CTL_LOOP >= $bits(channel_control))
        $error("rfdma_channel: enable or loop bit outside the control register");
    if (RFDMA_CTL_DIR >= $bits(channel_control) || RFDMA_CTL_IE >= $bits(channel_control))
        $error("rfdma_channel: direction or interrupt bit outside the control register");
    if (RFDMA_CTL_WORD >= $bits(channel_control) || RFDMA_CTL_TRIG_HI >= $bits(channel_control))
        $error("rfdma_channel: word or trigger bits outside the control register");
    if (RFDMA_HI_START_HI - RFDMA_HI_START_LO + 1 != $bits(start_hi_saved))
        $error("rfdma_channel: start nibble must match the saved start width");
    if (RFDMA_HI_END_HI - RFDMA_HI_END_LO + 1 != $bits(end_hi))
        $error("rfdma_channel: end nibble must match the end width");
    if (RFDMA_HI_START_LO <= RFDMA_HI_END_HI)
        $error("rfdma_channel: start and end nibbles overlap");
    if ($bits(RFDMA_IDX_CTRL) != RFDMA_IDX_W)
        $error("rfdma_channel: register index width disagrees with the map");

    // ------------------------------------------------------------
    // Avalon-MM slave, one wait state
    // ------------------------------------------------------------
    logic av_ack;
    logic av_req;
    logic av_wr_now;
    logic [RFDMA_IDX_W-1:0] av_idx;
    logic [7:0] rd_mux;

    assign av_req = avs_read | avs_write;
    assign avs_waitrequest = av_req & ~av_ack;
    assign av_wr_now = avs_write & av_ack & avs_byteenable[0];
    assign av_idx = avs_address[RFDMA_IDX_LSB +: RFDMA_IDX_W];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            av_ack <= 1'b0;
        else
            av_ack <= av_req & ~av_ack;
    end

    always_comb
    begin
        rd_mux = 8'h00;
        case (av_idx)
            RFDMA_IDX_CTRL: rd_mux = channel_control;
            RFDMA_IDX_PERIPH: rd_mux = peripheral_reg_address;
            RFDMA_IDX_HIGH: rd_mux = {cur_addr[11:8], end_hi};
            RFDMA_IDX_START: rd_mux = cur_addr[7:0];
            RFDMA_IDX_END: rd_mux = end_address_low;
            default: rd_mux = 8'h00;
        endcase
    end

    // Unmapped words read zero; upper bytes always zero
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & ~av_ack)
            avs_readdata <= {24'h00_0000, rd_mux};
    end

    // ------------------------------------------------------------
    // Register writes and hardware updates
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            channel_control <= RFDMA_REG_RESET;
        else if (av_wr_now && av_idx == RFDMA_IDX_CTRL)
            channel_control <= avs_writedata[7:0];
        else if (move_done && at_end && !channel_control[RFDMA_CTL_LOOP])
            channel_control[RFDMA_CTL_EN] <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            peripheral_reg_address <= RFDMA_REG_RESET;
            end_hi <= RFDMA_REG_RESET[3:0];
            end_address_low <= RFDMA_REG_RESET;
        end
        else if (av_wr_now)
        begin
            if (av_idx == RFDMA_IDX_PERIPH)
                peripheral_reg_address <= avs_writedata[7:0];
            if (av_idx == RFDMA_IDX_HIGH)
                end_hi <= avs_writedata[RFDMA_HI_END_HI:RFDMA_HI_END_LO];
            if (av_idx == RFDMA_IDX_END)
                end_address_low <= avs_writedata[7:0];
        end
    end

    // Start kept aside so a loop can reload it after the pointer has moved
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            start_hi_saved <= RFDMA_REG_RESET[3:0];
            start_lo_saved <= RFDMA_REG_RESET;
        end
        else if (av_wr_now)
        begin
            if (av_idx == RFDMA_IDX_HIGH)
                start_hi_saved <= avs_writedata[RFDMA_HI_START_HI:RFDMA_HI_START_LO];
            if (av_idx == RFDMA_IDX_START)
                start_lo_saved <= avs_writedata[7:0];
        end
    end

    // Software write to the pointer wins over a stepping transfer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            cur_addr <= {RFDMA_REG_RESET[3:0], RFDMA_REG_RESET};
        else if (av_wr_now && av_idx == RFDMA_IDX_HIGH)
            cur_addr[11:8] <= avs_writedata[RFDMA_HI_START_HI:RFDMA_HI_START_LO];
        else if (av_wr_now && av_idx == RFDMA_IDX_START)
            cur_addr[7:0] <= avs_writedata[7:0];
        else if (move_done && at_end)
            cur_addr <= {start_hi_saved, start_lo_saved};
        else if (move_done)
            cur_addr <= cur_addr + 12'h001;
    end

    // ------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------
    assign at_end = (cur_addr == {end_hi, end_address_low});
    assign periph_byte = peripheral_reg_address + {7'h00, second_byte};
    assign periph_full = {RFDMA_PERIPH_PAGE, periph_byte};
    assign src_addr = channel_control[RFDMA_CTL_DIR] ? periph_full : cur_addr;
    assign dst_addr = channel_control[RFDMA_CTL_DIR] ? cur_addr : periph_full;
    assign move_go = (state == RFDMA_MOVE);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= RFDMA_IDLE;
        end
        else
        begin
            case (state)
                RFDMA_IDLE:
                begin
                    if (trig_pulse && channel_control[RFDMA_CTL_EN])
                        state <= RFDMA_MOVE;
                end
                RFDMA_MOVE:
                    state <= RFDMA_WAIT;
                RFDMA_WAIT:
                    if (move_done)
                        state <= RFDMA_NEXT;
                RFDMA_NEXT:
                begin
                    if (pair_more)
                        state <= RFDMA_MOVE;
                    else
                        state <= RFDMA_IDLE;
                end
                default:
                    state <= RFDMA_IDLE;
            endcase
        end
    end

    // Remembers whether the byte just finished was the end-address byte
    logic last_was_end;

    function automatic logic dma_irq_block_end();
        return last_was_end;
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            last_was_end <= 1'b0;
        else if (move_done)
            last_was_end <= at_end;
    end

    // ------------------------------------------------------------
    // Two-byte pairing
    // ------------------------------------------------------------
    // Block end closes the request even in two-byte mode
    assign pair_more = channel_control[RFDMA_CTL_WORD] && !second_byte
        && channel_control[RFDMA_CTL_EN] && !dma_irq_block_end();

    // Picks the partner peripheral byte and marks the request's second half
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            second_byte <= 1'b0;
        else if (state == RFDMA_IDLE)
            second_byte <= 1'b0;
        else if (state == RFDMA_NEXT && pair_more)
            second_byte <= 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            dma_irq <= 1'b0;
        else
            dma_irq <= move_done & at_end & channel_control[RFDMA_CTL_IE];
    end

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    rfdma_trig_sel u_trig (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .trig_sel(channel_control[RFDMA_CTL_TRIG_HI:RFDMA_CTL_TRIG_LO]),
        .timer_req(timer_req),
        .uart_rx_valid(uart_rx_valid),
        .i2c_rx_valid(i2c_rx_valid),
        .trig_pulse(trig_pulse)
    );

    rfdma_byte_mover u_mover (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .go(move_go),
        .src_addr(src_addr),
        .dst_addr(dst_addr),
        .done(move_done),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_rd(mem_rd),
        .mem_wr(mem_wr),
        .mem_rdata(mem_rdata)
    );
endmodule

// [rfdma_checker_asserts.sv]
`timescale 1ns/1ns
module rfdma_checker
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic dma_irq
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("no wait state on new access");
    read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    move_pair_a: assert property (mem_rd |=> mem_wr && !mem_rd)
        else $error("read not followed by write");
    write_cause_a: assert property (mem_wr |-> $past(mem_rd))
        else $error("write without read");
    irq_cause_a: assert property (dma_irq |-> $past(mem_wr))
        else $error("interrupt without end transfer");
    irq_pulse_a: assert property (dma_irq |=> !dma_irq)
        else $error("interrupt longer than one cycle");
    periph_page_a: assert property (mem_rd ##1 mem_wr |-> mem_addr[11:8] == 4'hF
        || $past(mem_addr[11:8]) == 4'hF) else $error("peripheral side not in page F");
endmodule

bind rfdma_channel rfdma_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .dma_irq(dma_irq));

// [rfdma_mem_model.sv]
`timescale 1ns/1ns
module rfdma_mem_model
(
    input wire logic ref_clk,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    // Read answers within the read slot; the channel takes it on the edge ending the slot
    // Inverse outside the slot so an early or late sample never matches
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge ref_clk)
    begin
        if (mem_wr)
        begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

// [tb.sv]
`timescale 1ns/1ns
module tb;
    import rfdma_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [13:0] avs_address = 14'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [6:0] src = 7'h00;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_rdata;
    logic dma_irq;
    logic [31:0] rd;
    int fail_count = 0;
    int comparisons = 0;
    int wr_count = 0;
    int irq_count = 0;
    int w0;

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        wr_count <= wr_count + int'(mem_wr);
        irq_count <= irq_count + int'(dma_irq);
    end

    rfdma_channel dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_req(src[3:0]), .uart_rx_valid(src[5:4]),
        .i2c_rx_valid(src[6]), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_rdata(mem_rdata), .dma_irq(dma_irq));
    rfdma_mem_model far_mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    task automatic fire(input logic [6:0] v);
        @(posedge ref_clk);
        src <= v;
        @(posedge ref_clk);
        src <= 7'h00;
        repeat (16) @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 5; i++)
            rchk(RFDMA_IDX_CTRL + 12'(i), RFDMA_REG_RESET);
        bus(1'b1, RFDMA_IDX_END, 8'hC3);
        rchk(RFDMA_IDX_END, 8'hC3);
        bus(1'b1, 12'hFB5, 8'h77);
        rchk(12'hFB5, 8'h00);
        avs_byteenable <= 4'h0;
        bus(1'b1, RFDMA_IDX_END, 8'h11);
        avs_byteenable <= 4'hF;
        rchk(RFDMA_IDX_END, 8'hC3);
    endtask

    task automatic t_single();
        far_mem.mem[12'h123] = 8'hA5;
        far_mem.mem[12'h124] = 8'h3C;
        bus(1'b1, RFDMA_IDX_HIGH, 8'h11);
        bus(1'b1, RFDMA_IDX_START, 8'h23);
        bus(1'b1, RFDMA_IDX_END, 8'h24);
        bus(1'b1, RFDMA_IDX_PERIPH, 8'h40);
        bus(1'b1, RFDMA_IDX_CTRL, 8'h91);
        fire(7'h02);
        chk(far_mem.mem[12'hF40], 8'hA5);
        rchk(RFDMA_IDX_START, 8'h24);
        chk(irq_count, 0);
        fire(7'h02);
        chk(far_mem.mem[12'hF40], 8'h3C);
        chk(irq_count, 1);
        rchk(RFDMA_IDX_CTRL, 8'h11);
        w0 = wr_count;
        fire(7'h02);
        chk(wr_count, w0);
    endtask

    task automatic t_word();
        far_mem.mem[12'hF50] = 8'h11;
        far_mem.mem[12'hF51] = 8'h22;
        bus(1'b1, RFDMA_IDX_HIGH, 8'h22);
        bus(1'b1, RFDMA_IDX_START, 8'h00);
        bus(1'b1, RFDMA_IDX_END, 8'h01);
        bus(1'b1, RFDMA_IDX_PERIPH, 8'h50);
        w0 = wr_count;
        bus(1'b1, RFDMA_IDX_CTRL, 8'hEC);
        fire(7'h10);
        chk(far_mem.mem[12'h200], 8'h11);
        chk(far_mem.mem[12'h201], 8'h22);
        chk(wr_count - w0, 2);
        rchk(RFDMA_IDX_START, 8'h00);
        rchk(RFDMA_IDX_CTRL, 8'hEC);
        chk(irq_count, 1);
    endtask

    task automatic t_codes();
        far_mem.mem[12'h300] = 8'h9D;
        bus(1'b1, RFDMA_IDX_HIGH, 8'h33);
        bus(1'b1, RFDMA_IDX_END, 8'h00);
        bus(1'b1, RFDMA_IDX_PERIPH, 8'h60);
        for (int c = 0; c < 7; c++)
        begin
            bus(1'b1, RFDMA_IDX_START, 8'h00);
            bus(1'b1, RFDMA_IDX_CTRL, 8'hC0 | 8'(c));
            w0 = wr_count;
            fire(~(7'h01 << c));
            chk(wr_count, w0);
            fire(7'h01 << c);
            chk(wr_count, w0 + 1);
        end
        bus(1'b1, RFDMA_IDX_CTRL, {5'h18, RFDMA_TRIG_RSVD});
        fire(7'h7F);
        chk(wr_count, w0 + 1);
        bus(1'b1, RFDMA_IDX_CTRL, {5'h08, RFDMA_TRIG_I2C});
        fire(7'h40);
        chk(wr_count, w0 + 1);
    endtask

    task automatic t_reset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rchk(RFDMA_IDX_CTRL + 12'(i), RFDMA_REG_RESET);
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_single();
        t_word();
        t_codes();
        t_reset();
        summarize();
    end

    // Whole run needs about 520 cycles
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule
